// *** rtl/usbsd_string_regs.sv ***
// string descriptor register bank with descriptor byte lookup
`timescale 1ns/1ps

// How it works
// RULE_01: url text length counts 16-bit characters, capped at 120 characters.
// RULE_02: url descriptor bLength is two plus twice the url character count.
// RULE_03: altmode text length counts characters, capped at 120 characters.
// RULE_04: altmode descriptor bLength is two plus twice its character count.
// RULE_05: both lengths reset to zero; zero selects the built-in default character count.
// RULE_06: string index 1 returns the serial bytes.
// RULE_07: serial bytes hold a factory value, writable only with custom serial select.
// RULE_08: string index 3 returns maker bytes when maker length is nonzero.
// RULE_09: maker payload byte count equals the maker length setting, capped at 64 bytes.
// RULE_10: string index 2 returns product bytes when product length is nonzero.
// RULE_11: product payload byte count equals the product length setting, capped at 64 bytes.
// RULE_12: the programming party should supply utf-16le characters.
// RULE_13: billboard text storage is write-only, texts at 0x100 and 0x1f0.
// RULE_14: zero maker or product length falls back to a built-in default text.
module usbsd_string_regs
	import usbsd_pkg::*;
(
	// clock, reset, enable
	input  wire logic       sys_clk,
	input  wire logic       reset,
	input  wire logic       ce,
	// configuration straps and lengths
	input  wire logic       custom_serial_select,
	input  wire logic [7:0] maker_text_len,
	input  wire logic [7:0] product_text_len,
	// eeprom / smbus register port
	input  wire logic [9:0] cfg_addr,
	input  wire logic       cfg_wr,
	input  wire logic [7:0] cfg_wdata,
	input  wire logic       cfg_rd,
	output logic      [7:0] cfg_rdata,
	// descriptor lookup port
	input  wire logic       desc_rd,
	input  wire logic [7:0] desc_index,
	input  wire logic [7:0] desc_offset,
	output logic            desc_valid,
	output logic      [7:0] desc_data,
	output logic      [7:0] desc_blength
);

	// ------------------------------------------------------------------
	// state
	// ------------------------------------------------------------------
	typedef struct packed {
		logic [7:0]                    url_text_length;
		logic [7:0]                    altmode_text_length;
		logic [SERIAL_BYTES-1:0][7:0]  serial_text_bytes;
		logic [MAKER_BYTES-1:0][7:0]   maker_text_bytes;
		logic [PRODUCT_BYTES-1:0][7:0] product_text_bytes;
		logic [7:0]                    cfg_rdata;
		logic                          desc_valid;
		logic [7:0]                    desc_data;
		logic [7:0]                    desc_blength;
	} usbsd_state_t;

	usbsd_state_t st;
	usbsd_state_t next_st;

	// default billboard text storage, no reset
	logic [7:0] billboard_default_text [BB_BYTES];

	// ------------------------------------------------------------------
	// helpers
	// ------------------------------------------------------------------
	function automatic logic in_range(input logic [9:0] addr, input logic [9:0] base,
		input int count);
		in_range = (addr >= base) && ({22'h0, addr} < ({22'h0, base} + 32'(count)));
	endfunction

	function automatic logic [7:0] clamp(input logic [7:0] val, input logic [7:0] lim);
		clamp = (val > lim) ? lim : val;
	endfunction

	// built-in fallback text, utf-16le
	function automatic logic [7:0] default_text(input logic maker, input logic [7:0] ofs);
		logic [63:0] txt;
		txt = maker ? 64'h0064_006e_0065_0056 : 64'h0000_0062_0075_0048;
		default_text = txt[{ofs[2:0], 3'b000} +: 8];
	endfunction

	// zero selects the built-in default, anything else is capped
	function automatic logic [7:0] effective_len(input logic [7:0] raw,
		input logic [7:0] fallback, input logic [7:0] lim);
		if (raw == RST_LEN) begin
			effective_len = fallback;
		end else begin
			effective_len = clamp(raw, lim);
		end
	endfunction

	// ------------------------------------------------------------------
	// register map decode
	// ------------------------------------------------------------------
	typedef enum logic [2:0] {
		REGION_NONE,
		REGION_URL_LEN,
		REGION_ALT_LEN,
		REGION_SERIAL,
		REGION_MAKER,
		REGION_PRODUCT,
		REGION_BILLBOARD
	} usbsd_region_t;

	// which storage a byte address falls in; holes decode to none
	function automatic usbsd_region_t decode_region(input logic [9:0] addr);
		if (addr == OFS_URL_LEN) begin
			decode_region = REGION_URL_LEN;
		end else if (addr == OFS_ALT_LEN) begin
			decode_region = REGION_ALT_LEN;
		end else if (in_range(addr, OFS_SERIAL, SERIAL_BYTES)) begin
			decode_region = REGION_SERIAL;
		end else if (in_range(addr, OFS_MAKER, MAKER_BYTES)) begin
			decode_region = REGION_MAKER;
		end else if (in_range(addr, OFS_PRODUCT, PRODUCT_BYTES)) begin
			decode_region = REGION_PRODUCT;
		end else if (in_range(addr, OFS_BB_BASE, BB_BYTES)) begin
			decode_region = REGION_BILLBOARD;
		end else begin
			decode_region = REGION_NONE;
		end
	endfunction

	// byte position of an address inside its region
	function automatic logic [9:0] region_offset(input logic [9:0] addr,
		input usbsd_region_t region);
		case (region)
			REGION_SERIAL:    region_offset = addr - OFS_SERIAL;
			REGION_MAKER:     region_offset = addr - OFS_MAKER;
			REGION_PRODUCT:   region_offset = addr - OFS_PRODUCT;
			REGION_BILLBOARD: region_offset = addr - OFS_BB_BASE;
			default:          region_offset = 10'h000;
		endcase
	endfunction

	// ------------------------------------------------------------------
	// next state
	// ------------------------------------------------------------------
	logic [7:0] url_chars;
	logic [7:0] alt_chars;
	logic [7:0] maker_len;
	logic [7:0] product_len;
	logic [7:0] pay_len;
	logic [7:0] pay_byte;
	logic [7:0] pay_ofs;
	logic [9:0] rel;

	// ------------------------------------------------------------------
	// register port address decode
	// ------------------------------------------------------------------
	usbsd_region_t cfg_region;

	assign cfg_region = decode_region(cfg_addr);
	assign rel        = region_offset(cfg_addr, cfg_region);

	always_comb begin
		next_st     = st;
		pay_ofs     = desc_offset - DESC_HDR_BYTES;
		url_chars   = effective_len(st.url_text_length, DEF_URL_CHARS,
			MAX_CHARS); // RULE_01 RULE_05
		alt_chars   = effective_len(st.altmode_text_length, DEF_ALT_CHARS,
			MAX_CHARS); // RULE_03 RULE_05
		maker_len   = effective_len(maker_text_len, DEF_MAKER_LEN,
			MAX_TEXT_BYTES); // RULE_09 RULE_14
		product_len = effective_len(product_text_len, DEF_PRODUCT_LEN,
			MAX_TEXT_BYTES); // RULE_11 RULE_14
		pay_len     = 8'h00;
		pay_byte    = 8'h00;

		// payload selection by string index
		case (desc_index)
			IDX_SERIAL: begin
				pay_len  = SERIAL_LEN;
				pay_byte = st.serial_text_bytes[pay_ofs[4:0]]; // RULE_06
			end
			IDX_PRODUCT: begin
				pay_len  = product_len;
				pay_byte = (product_text_len == RST_LEN) ? default_text(1'b0, pay_ofs)
					: st.product_text_bytes[pay_ofs[5:0]]; // RULE_10 RULE_14
			end
			IDX_MAKER: begin
				pay_len  = maker_len;
				pay_byte = (maker_text_len == RST_LEN) ? default_text(1'b1, pay_ofs)
					: st.maker_text_bytes[pay_ofs[5:0]]; // RULE_08 RULE_14
			end
			IDX_URL: begin
				pay_len  = 8'({url_chars, 1'b0}); // RULE_02
				pay_byte = billboard_default_text[9'(pay_ofs)]; // RULE_13
			end
			IDX_ALTMODE: begin
				pay_len  = 8'({alt_chars, 1'b0}); // RULE_04
				pay_byte = billboard_default_text[9'(OFS_BB_ALT - OFS_BB_BASE)
					+ 9'(pay_ofs)]; // RULE_13
			end
			default: begin
				pay_len  = 8'h00;
				pay_byte = 8'h00;
			end
		endcase

		if (ce) begin
			// register writes
			if (cfg_wr) begin
				case (cfg_region)
					REGION_URL_LEN: begin
						next_st.url_text_length = cfg_wdata; // RULE_05
					end
					REGION_ALT_LEN: begin
						next_st.altmode_text_length = cfg_wdata; // RULE_05
					end
					REGION_SERIAL: begin
						if (custom_serial_select) begin
							next_st.serial_text_bytes[rel[4:0]] = cfg_wdata; // RULE_07
						end
					end
					REGION_MAKER: begin
						next_st.maker_text_bytes[rel[5:0]] = cfg_wdata;
					end
					REGION_PRODUCT: begin
						next_st.product_text_bytes[rel[5:0]] = cfg_wdata;
					end
					default: begin
					end
				endcase
			end

			// register reads; billboard storage and holes read zero
			if (cfg_rd) begin
				case (cfg_region)
					REGION_URL_LEN: begin
						next_st.cfg_rdata = st.url_text_length;
					end
					REGION_ALT_LEN: begin
						next_st.cfg_rdata = st.altmode_text_length;
					end
					REGION_SERIAL: begin
						next_st.cfg_rdata = st.serial_text_bytes[rel[4:0]];
					end
					REGION_MAKER: begin
						next_st.cfg_rdata = st.maker_text_bytes[rel[5:0]];
					end
					REGION_PRODUCT: begin
						next_st.cfg_rdata = st.product_text_bytes[rel[5:0]];
					end
					REGION_BILLBOARD: begin
						next_st.cfg_rdata = 8'h00; // RULE_13
					end
					default: begin
						next_st.cfg_rdata = 8'h00;
					end
				endcase
			end

			// descriptor byte: length, type, then payload
			next_st.desc_valid = desc_rd;
			if (desc_rd) begin
				next_st.desc_blength = (pay_len == 8'h00) ? 8'h00
					: pay_len + DESC_HDR_BYTES; // RULE_02 RULE_04
				if (pay_len == 8'h00) begin
					next_st.desc_data = 8'h00;
				end else if (desc_offset == 8'h00) begin
					next_st.desc_data = pay_len + DESC_HDR_BYTES;
				end else if (desc_offset == 8'h01) begin
					next_st.desc_data = DESC_TYPE_STRING;
				end else if (pay_ofs < pay_len) begin
					next_st.desc_data = pay_byte; // RULE_09 RULE_11
				end else begin
					next_st.desc_data = 8'h00;
				end
			end
		end
	end

	// ------------------------------------------------------------------
	// registers
	// ------------------------------------------------------------------
	always_ff @(posedge sys_clk or posedge reset) begin
		if (reset) begin
			st                     <= '0;
			st.url_text_length     <= RST_LEN; // RULE_05
			st.altmode_text_length <= RST_LEN; // RULE_05
			st.serial_text_bytes   <= SERIAL_DEFAULT; // RULE_07
		end else begin
			st <= next_st;
		end
	end

	// write-only billboard storage
	always_ff @(posedge sys_clk) begin
		if (ce && cfg_wr && (cfg_region == REGION_BILLBOARD)) begin
			billboard_default_text[rel[8:0]] <= cfg_wdata; // RULE_13
		end
	end

	// ------------------------------------------------------------------
	// outputs
	// ------------------------------------------------------------------
	assign cfg_rdata    = st.cfg_rdata;
	assign desc_valid   = st.desc_valid;
	assign desc_data    = st.desc_data;
	assign desc_blength = st.desc_blength;

endmodule // usbsd_string_regs

// *** rtl/usbsd_pkg.sv ***
// constants for the usb string descriptor register bank
package usbsd_pkg;

	// ------------------------------------------------------------------
	// register offsets and sizes
	// ------------------------------------------------------------------
	localparam logic [9:0] OFS_URL_LEN     = 10'h02c;
	localparam logic [9:0] OFS_ALT_LEN     = 10'h02d;
	localparam logic [9:0] OFS_SERIAL      = 10'h030;
	localparam logic [9:0] OFS_MAKER       = 10'h050;
	localparam logic [9:0] OFS_PRODUCT     = 10'h090;
	localparam logic [9:0] OFS_BB_BASE     = 10'h100;
	localparam logic [9:0] OFS_BB_ALT      = 10'h1f0;
	localparam int         SERIAL_BYTES    = 32;
	localparam int         MAKER_BYTES     = 64;
	localparam int         PRODUCT_BYTES   = 64;
	localparam int         BB_BYTES        = 480;

	// ------------------------------------------------------------------
	// reset values and limits
	// ------------------------------------------------------------------
	localparam logic [7:0] RST_LEN         = 8'h00;
	localparam logic [7:0] RST_BYTE        = 8'h00;
	localparam logic [7:0] MAX_CHARS       = 8'h78;
	localparam logic [7:0] MAX_TEXT_BYTES  = 8'h40;
	localparam logic [7:0] SERIAL_LEN      = 8'h20;
	// arbitrary factory serial value
	localparam logic [255:0] SERIAL_DEFAULT = {16{16'h0030}};

	// ------------------------------------------------------------------
	// descriptor encoding
	// ------------------------------------------------------------------
	localparam logic [7:0] DESC_TYPE_STRING = 8'h03;
	localparam logic [7:0] DESC_HDR_BYTES   = 8'h02;
	localparam logic [7:0] IDX_SERIAL       = 8'h01;
	localparam logic [7:0] IDX_PRODUCT      = 8'h02;
	localparam logic [7:0] IDX_MAKER        = 8'h03;
	localparam logic [7:0] IDX_URL          = 8'h04;
	localparam logic [7:0] IDX_ALTMODE      = 8'h05;
	// built-in default lengths
	localparam logic [7:0] DEF_URL_CHARS    = 8'h10;
	localparam logic [7:0] DEF_ALT_CHARS    = 8'h08;
	localparam logic [7:0] DEF_MAKER_LEN    = 8'h08;
	localparam logic [7:0] DEF_PRODUCT_LEN  = 8'h06;

endpackage

// *** dv/usbsd_string_regs_properties.sv ***
// assertion checker for the string descriptor register bank
`timescale 1ns/1ps
module usbsd_string_regs_chk
	import usbsd_pkg::*;
(
	// clock and reset
	input wire logic       sys_clk,
	input wire logic       reset,
	// enable, text lengths and descriptor port
	input wire logic       ce,
	input wire logic [7:0] maker_text_len,
	input wire logic [7:0] product_text_len,
	input wire logic       desc_rd,
	input wire logic [7:0] desc_index,
	input wire logic [7:0] desc_offset,
	input wire logic       desc_valid,
	input wire logic [7:0] desc_data,
	input wire logic [7:0] desc_blength
);
	default clocking @(posedge sys_clk); endclocking
	default disable iff (reset);
	// ----
	// request sequences
	// ----
	sequence take;
		ce && desc_rd;
	endsequence
	sequence ask(logic [7:0] idx);
		take ##0 desc_index == idx;
	endsequence
	AST_VALID: assert property (take |=> desc_valid)
		else $error("no valid after request");
	AST_IDLE: assert property (ce && !desc_rd |=> !desc_valid && $stable(desc_data))
		else $error("descriptor output moved without request");
	AST_FREEZE: assert property (!ce |=> $stable(desc_valid) && $stable(desc_data)
		&& $stable(desc_blength)) else $error("descriptor outputs moved while disabled");
	AST_SERIAL_LEN: assert property (ask(IDX_SERIAL) |=> desc_blength == 8'h22)
		else $error("serial length wrong");
	AST_TYPE: assert property (ask(IDX_SERIAL) ##0 desc_offset == 8'h01 |=> desc_data == 8'h03)
		else $error("type byte wrong");
	AST_MAKER_LEN: assert property (ask(IDX_MAKER) ##0 maker_text_len inside {[8'h01:8'h40]}
		|=> desc_blength == $past(maker_text_len) + 8'h02) else $error("maker length wrong");
	AST_MAKER_DEF: assert property (ask(IDX_MAKER) ##0 maker_text_len == 8'h00
		|=> desc_blength == DEF_MAKER_LEN + 8'h02) else $error("maker default wrong");
	AST_PROD_LEN: assert property (ask(IDX_PRODUCT) ##0 product_text_len inside {[8'h01:8'h40]}
		|=> desc_blength == $past(product_text_len) + 8'h02) else $error("product length wrong");
	AST_PROD_DEF: assert property (ask(IDX_PRODUCT) ##0 product_text_len == 8'h00
		|=> desc_blength == DEF_PRODUCT_LEN + 8'h02) else $error("product default wrong");
	AST_BEYOND: assert property (ask(IDX_MAKER) ##0 maker_text_len inside {[8'h01:8'h40]}
		##0 desc_offset >= maker_text_len + 8'h02 |=> desc_data == 8'h00)
		else $error("byte past maker text not zero");
endmodule // usbsd_string_regs_chk

bind usbsd_string_regs usbsd_string_regs_chk chk_i (.sys_clk, .reset, .ce, .maker_text_len,
	.product_text_len, .desc_rd, .desc_index, .desc_offset, .desc_valid, .desc_data, .desc_blength);

// *** dv/usbsd_host_model.sv ***
// descriptor host and configuration loader model
`timescale 1ns/1ps
module usbsd_host_model (
	// clock
	input  wire logic       sys_clk,
	// register port
	output logic      [9:0] cfg_addr,
	output logic            cfg_wr,
	output logic      [7:0] cfg_wdata,
	output logic            cfg_rd,
	input  wire logic [7:0] cfg_rdata,
	// descriptor port
	output logic            desc_rd,
	output logic      [7:0] desc_index,
	output logic      [7:0] desc_offset,
	input  wire logic       desc_valid,
	input  wire logic [7:0] desc_data,
	input  wire logic [7:0] desc_blength
);
	initial begin
		{cfg_addr, cfg_wr, cfg_wdata, cfg_rd} = '0;
		{desc_rd, desc_index, desc_offset} = '0;
	end
	// one byte, held across one taking edge, released lines scrambled
	task cfg_op(input logic [9:0] a, input logic w, input logic [7:0] d, input logic r,
		output logic [7:0] q);
		@(negedge sys_clk);
		{cfg_addr, cfg_wr, cfg_wdata, cfg_rd} = {a, w, d, r};
		@(negedge sys_clk);
		{cfg_addr, cfg_wr, cfg_wdata, cfg_rd} = {~a, 1'b0, ~d, 1'b0};
		q = cfg_rdata;
	endtask
	task desc_op(input logic [7:0] i, input logic [7:0] o, output logic [7:0] q,
		output logic [7:0] b, output logic v);
		@(negedge sys_clk);
		{desc_rd, desc_index, desc_offset} = {1'b1, i, o};
		@(negedge sys_clk);
		{desc_rd, desc_index, desc_offset} = {1'b0, ~i, ~o};
		{q, b, v} = {desc_data, desc_blength, desc_valid};
	endtask
endmodule // usbsd_host_model

// *** dv/test_usb_string_descriptor_regs.sv ***
// self-checking bench for the string descriptor register bank
`timescale 1ns/1ps
module test_usb_string_descriptor_regs
	import usbsd_pkg::*;
;
	logic        sys_clk, reset, ce, custom_serial_select, cfg_wr, cfg_rd, desc_rd, desc_valid, v;
	logic [7:0]  maker_text_len, product_text_len, cfg_wdata, cfg_rdata, q, b;
	logic [7:0]  desc_index, desc_offset, desc_data, desc_blength;
	logic [9:0]  cfg_addr;
	int          num_errors, n_checks;
	// index, offset, maker len, product len, data, blength
	logic [47:0] rows [17] = '{48'h01000000_2222, 48'h01010000_0322, 48'h01020000_3022,
		48'h01030000_0022, 48'h01200000_3022, 48'h01220000_0022, 48'h03020000_560a,
		48'h03040000_650a, 48'h03000500_0707, 48'h03070500_0007, 48'h03004600_4242,
		48'h02020000_4808, 48'h02060000_6208, 48'h02000040_4242, 48'h04000000_2222,
		48'h05000000_1212, 48'h06000000_0000};
	usbsd_string_regs usbsd_string_regs_i (.sys_clk, .reset, .ce, .custom_serial_select,
		.maker_text_len, .product_text_len, .cfg_addr, .cfg_wr, .cfg_wdata, .cfg_rd, .cfg_rdata,
		.desc_rd, .desc_index, .desc_offset, .desc_valid, .desc_data, .desc_blength);
	usbsd_host_model usbsd_host_model_i (.sys_clk, .cfg_addr, .cfg_wr, .cfg_wdata, .cfg_rd,
		.cfg_rdata, .desc_rd, .desc_index, .desc_offset, .desc_valid, .desc_data, .desc_blength);
	// ----
	// helpers
	// ----
	task chk(input logic [7:0] got, input logic [7:0] exp);
		n_checks++;
		if (got !== exp) begin
			$display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
			num_errors++;
		end
	endtask
	task wr(input logic [9:0] a, input logic [7:0] d);
		usbsd_host_model_i.cfg_op(a, 1'b1, d, 1'b0, q);
	endtask
	task rd(input logic [9:0] a, input logic [7:0] e);
		usbsd_host_model_i.cfg_op(a, 1'b0, 8'h00, 1'b1, q);
		chk(q, e);
	endtask
	task dq(input logic [7:0] i, input logic [7:0] o, input logic [7:0] ed, input logic [7:0] eb);
		usbsd_host_model_i.desc_op(i, o, q, b, v);
		chk({7'h00, v}, 8'h01);
		chk(q, ed);
		chk(b, eb);
	endtask
	task end_of_test;
		$display("checks=%0d errors=%0d", n_checks, num_errors);
		if (num_errors == 0 && n_checks > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	initial begin
		sys_clk = 1'b0;
		forever #12.5 sys_clk = ~sys_clk;
	end
	initial begin
		#100000;
		num_errors++;
		end_of_test;
	end
	// ----
	// sequence
	// ----
	initial begin
		{reset, ce, custom_serial_select, maker_text_len, product_text_len} = {3'b110, 16'h0000};
		{num_errors, n_checks} = '0;
		repeat (4) @(negedge sys_clk);
		chk(desc_blength, 8'h00);
		reset = 1'b0;
		rd(10'h02c, 8'h00);
		rd(10'h02d, 8'h00);
		foreach (rows[k]) begin
			{maker_text_len, product_text_len} = rows[k][31:16];
			dq(rows[k][47:40], rows[k][39:32], rows[k][15:8], rows[k][7:0]);
		end
		wr(10'h100, 8'h41);
		wr(10'h1f0, 8'h42);
		rd(10'h100, 8'h00);
		wr(10'h02c, 8'h01);
		rd(10'h02c, 8'h01);
		dq(8'h04, 8'h02, 8'h41, 8'h04);
		wr(10'h02c, 8'hc8);
		dq(8'h04, 8'h00, 8'hf2, 8'hf2);
		wr(10'h02d, 8'h78);
		dq(8'h05, 8'h02, 8'h42, 8'hf2);
		wr(10'h02d, 8'h79);
		dq(8'h05, 8'h00, 8'hf2, 8'hf2);
		wr(10'h02d, 8'h03);
		dq(8'h05, 8'h00, 8'h08, 8'h08);
		wr(10'h030, 8'hab);
		rd(10'h030, 8'h30);
		custom_serial_select = 1'b1;
		wr(10'h030, 8'hab);
		rd(10'h030, 8'hab);
		dq(8'h01, 8'h02, 8'hab, 8'h22);
		wr(10'h050, 8'h4d);
		wr(10'h090, 8'h50);
		{maker_text_len, product_text_len} = 16'h0202;
		dq(8'h03, 8'h02, 8'h4d, 8'h04);
		dq(8'h02, 8'h02, 8'h50, 8'h04);
		rd(10'h3ff, 8'h00);
		ce = 1'b0;
		usbsd_host_model_i.desc_op(8'h01, 8'h00, q, b, v);
		chk({7'h00, v}, 8'h00);
		ce = 1'b1;
		reset = 1'b1;
		@(negedge sys_clk);
		reset = 1'b0;
		rd(10'h02c, 8'h00);
		rd(10'h030, 8'h30);
		end_of_test;
	end
endmodule // test_usb_string_descriptor_regs
